// file: i2cmr_top.sv
// Purpose: I2C master sequencer for start, address, byte reception, ack and stop.
// Assumes: Open-drain SDA/SCL; software drives one-cycle request pulses.
// Notes: Received bytes pass an 8-word FIFO before reaching the data buffer.
//
// Overview of operation
// - Buffer write during reception sets collision, dropped.
// - Start request; interrupt flag when start completes.
// - Address write starts shifting eight bits immediately.
// - Sample slave acknowledge into ack status.
// - Interrupt flag at end of ninth clock.
// - Receive enable clocks in one slave byte.
// - After eighth falling edge: interrupt and full.
// - Reading buffer clears buffer-full flag.
// - Software picks ack bit, then starts sequence.
// - Clock out ack bit, then interrupt flag.
// - Receive enable ignored unless port idle and FIFO has room.
// - After byte: clear enable, load, hold SCL.
// - Byte done while buffer full sets overflow.
`timescale 1ns/1ps
`default_nettype none
module i2cmr_top
  import i2cmr_pkg::*;
#(
  parameter int HALF_CYCLES = i2cmr_pkg::SCL_HALF_CYCLES,
  parameter int DEPTH = i2cmr_pkg::FIFO_DEPTH
) (
  input wire logic clk, // system clock, 40 MHz
  input wire logic nrst, // asynchronous reset, active low
  input wire logic buf_wr, // pulse: write to the data buffer
  input wire logic [i2cmr_pkg::DATA_W-1:0] buf_wdata, // address byte written
  input wire logic buf_rd, // pulse: read of the data buffer
  input wire logic start_req, // pulse: set start_condition_enable
  input wire logic receive_req, // pulse: set receive_enable_bit
  input wire logic ack_req, // pulse: set ack_sequence_enable
  input wire logic ack_response_bit, // 0 acknowledge, 1 not-acknowledge
  input wire logic stop_req, // pulse: request a stop condition
  input wire logic int_clear, // pulse: clear port_interrupt_flag
  input wire logic write_collision_flag_clear, // pulse: clear write_collision_flag
  input wire logic ovf_clear, // pulse: clear receive_overflow_flag
  input wire logic sda_in, // SDA line level
  output logic sda_out, // SDA drive value, always low
  output logic sda_oe_n, // SDA enable, low while pulling low
  input wire logic scl_in, // SCL line level
  output logic scl_out, // SCL drive value, always low
  output logic scl_oe_n, // SCL enable, low while pulling low
  output logic [i2cmr_pkg::DATA_W-1:0] serial_data_buffer, // received byte
  output logic buffer_full_flag, // buffer holds an unread byte
  output logic port_interrupt_flag, // sticky event flag
  output logic write_collision_flag, // sticky collision flag
  output logic receive_overflow_flag, // sticky overflow flag
  output logic ack_status_bit, // acknowledge bit sampled from the slave, 1 not-acknowledge
  output logic start_condition_enable, // start in progress
  output logic receive_enable_bit, // reception in progress
  output logic ack_sequence_enable, // ack sequence in progress
  output logic port_idle // sequencer idle
);
  import i2cmr_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers with agreement filter
  // ---------------------------------------------------------------
  logic [2:0] sda_sync;
  logic [2:0] scl_sync;
  logic sda_f;
  logic scl_f;
  logic next_sda_f;
  logic next_scl_f;

  always_comb
  begin
    next_sda_f = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_f;
    next_scl_f = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_f;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sda_sync <= 3'h7;
      scl_sync <= 3'h7;
      sda_f <= 1'b1;
      scl_f <= 1'b1;
    end
    else
    begin
      sda_sync <= {sda_sync[1:0], sda_in};
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_f <= next_sda_f;
      scl_f <= next_scl_f;
    end
  end

  // ---------------------------------------------------------------
  // Receive FIFO and data buffer stage
  // ---------------------------------------------------------------
  logic push;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [DATA_W-1:0] fifo_out_data;
  logic [DATA_W-1:0] shreg;
  logic [DATA_W-1:0] push_data;

  i2cmr_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  localparam logic [15:0] HALF_LAST = 16'(HALF_CYCLES - 1);

  i2cmr_state_e state;
  i2cmr_state_e next_state;
  logic [15:0] brg;
  logic [15:0] next_brg;
  logic hi;
  logic next_hi;
  logic tick;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [DATA_W-1:0] next_shreg;
  logic sda_low;
  logic scl_low;
  logic next_sda_low;
  logic next_scl_low;
  logic [DATA_W-1:0] next_buffer;
  logic next_bf;
  logic next_pif;
  logic next_write_collision_flag;
  logic next_ovf;
  logic next_ack_status_bit;
  logic next_sen;
  logic next_receive_enable_bit;
  logic next_ack_sequence_enable;

  always_comb
  begin
    next_state = state;
    next_hi = hi;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_sda_low = sda_low;
    next_scl_low = scl_low;
    next_ack_status_bit = ack_status_bit;
    next_sen = start_condition_enable;
    next_receive_enable_bit = receive_enable_bit;
    next_ack_sequence_enable = ack_sequence_enable;
    push = 1'b0;
    push_data = {shreg[DATA_W-2:0], sda_f};
    // Clears first, so a set later in this process wins over a clear.
    next_pif = port_interrupt_flag && !int_clear;
    next_write_collision_flag = write_collision_flag && !write_collision_flag_clear;
    next_ovf = receive_overflow_flag && !ovf_clear;
    // The rate generator is suspended in idle and waits while a slave stretches SCL.
    tick = 1'b0;
    next_brg = brg;
    if (state == ST_IDLE)
    begin
      next_brg = '0;
    end
    else if (!(hi && !scl_f))
    begin
      tick = brg == HALF_LAST;
      next_brg = tick ? '0 : brg + 16'h0001;
    end
    case (state)
      ST_IDLE:
      begin
        next_hi = 1'b0;
        next_bitcnt = BIT_FIRST;
        if (start_req)
        begin
          next_sen = 1'b1;
          next_sda_low = 1'b1;
          next_state = ST_START;
        end
        else if (buf_wr)
        begin
          next_shreg = buf_wdata;
          next_sda_low = !buf_wdata[DATA_W-1];
          next_scl_low = 1'b1;
          next_state = ST_ADDR;
        end
        else if (receive_req && fifo_in_ready)
        begin
          next_receive_enable_bit = 1'b1;
          next_sda_low = 1'b0;
          next_scl_low = 1'b1;
          next_state = ST_RECV;
        end
        else if (ack_req)
        begin
          next_ack_sequence_enable = 1'b1;
          next_sda_low = !ack_response_bit;
          next_scl_low = 1'b1;
          next_state = ST_ACK;
        end
        else if (stop_req)
        begin
          next_sda_low = 1'b1;
          next_scl_low = 1'b1;
          next_state = ST_STOP;
        end
      end
      ST_START:
      begin
        if (tick)
        begin
          next_scl_low = 1'b1;
          next_sen = 1'b0;
          next_pif = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_STOP:
      begin
        if (tick && !hi)
        begin
          next_scl_low = 1'b0;
          next_hi = 1'b1;
        end
        else if (tick)
        begin
          next_sda_low = 1'b0;
          next_pif = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        if (tick && !hi)
        begin
          next_scl_low = 1'b0;
          next_hi = 1'b1;
        end
        else if (tick)
        begin
          // End of the high phase: pull SCL low again; SDA is sampled for received bits and the address ack.
          next_scl_low = 1'b1;
          next_hi = 1'b0;
          next_bitcnt = bitcnt + BIT_STEP;
          if (state == ST_ADDR)
          begin
            next_shreg = {shreg[DATA_W-2:0], 1'b0};
            next_sda_low = (bitcnt < BIT_LAST_DATA) && !shreg[DATA_W-2];
            if (bitcnt == BIT_ADDR_ACK)
            begin
              next_ack_status_bit = sda_f;
              next_pif = 1'b1;
              next_sda_low = 1'b0;
              next_state = ST_IDLE;
            end
          end
          else if (state == ST_RECV)
          begin
            next_shreg = push_data;
            if (bitcnt == BIT_LAST_DATA)
            begin
              push = 1'b1;
              next_receive_enable_bit = 1'b0;
              next_pif = 1'b1;
              if (buffer_full_flag)
              begin
                next_ovf = 1'b1;
              end
              next_state = ST_IDLE;
            end
          end
          else
          begin
            next_ack_sequence_enable = 1'b0;
            next_sda_low = 1'b0;
            next_pif = 1'b1;
            next_state = ST_IDLE;
          end
        end
      end
    endcase
    if (buf_wr && state == ST_RECV)
    begin
      next_write_collision_flag = 1'b1;
    end
    // A read frees the buffer; a queued byte moves in one edge later, so the flag drops.
    fifo_out_ready = !buffer_full_flag;
    next_buffer = serial_data_buffer;
    next_bf = buffer_full_flag && !buf_rd;
    if (fifo_out_valid && fifo_out_ready)
    begin
      next_buffer = fifo_out_data;
      next_bf = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= ST_IDLE;
      brg <= '0;
      hi <= 1'b0;
      bitcnt <= BIT_FIRST;
      shreg <= BYTE_ZERO;
      sda_low <= 1'b0;
      scl_low <= 1'b0;
      serial_data_buffer <= BYTE_ZERO;
      buffer_full_flag <= 1'b0;
      port_interrupt_flag <= 1'b0;
      write_collision_flag <= 1'b0;
      receive_overflow_flag <= 1'b0;
      ack_status_bit <= 1'b0;
      start_condition_enable <= 1'b0;
      receive_enable_bit <= 1'b0;
      ack_sequence_enable <= 1'b0;
      port_idle <= 1'b1;
      sda_oe_n <= 1'b1;
      scl_oe_n <= 1'b1;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      brg <= next_brg;
      hi <= next_hi;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      sda_low <= next_sda_low;
      scl_low <= next_scl_low;
      serial_data_buffer <= next_buffer;
      buffer_full_flag <= next_bf;
      port_interrupt_flag <= next_pif;
      write_collision_flag <= next_write_collision_flag;
      receive_overflow_flag <= next_ovf;
      ack_status_bit <= next_ack_status_bit;
      start_condition_enable <= next_sen;
      receive_enable_bit <= next_receive_enable_bit;
      ack_sequence_enable <= next_ack_sequence_enable;
      port_idle <= next_state == ST_IDLE;
      sda_oe_n <= !next_sda_low;
      scl_oe_n <= !next_scl_low;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end
  end
endmodule : i2cmr_top
`default_nettype wire

// file: i2cmr_pkg.sv
// Purpose: Shared constants and types for the I2C master byte receiver.
// Assumes: 40 MHz system clock, standard-mode SCL pacing.
// Notes: Timing counts are derived from times expressed in their own units.
package i2cmr_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int SCL_HALF_NS = 5000;
  // A least time, so the cycle count rounds up.
  localparam int SCL_HALF_CYCLES = (SCL_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ---------------------------------------------------------------
  // Data path
  // ---------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  localparam logic [3:0] BIT_ADDR_ACK = 4'h8;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_STEP = 4'h1;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_START = 6'h02,
    ST_ADDR  = 6'h04,
    ST_RECV  = 6'h08,
    ST_ACK   = 6'h10,
    ST_STOP  = 6'h20
  } i2cmr_state_e;

endpackage : i2cmr_pkg

// file: i2cmr_fifo.sv
// Purpose: Parameterised FIFO between the receive shifter and the data buffer.
// Assumes: Single clock; push and pop may happen in the same cycle.
// Notes: in_ready is low when full, out_valid is low when empty.
`timescale 1ns/1ps
`default_nettype none
module i2cmr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk, // system clock
  input wire logic nrst, // asynchronous reset, active low
  input wire logic in_valid, // push request
  output logic in_ready, // room for one word
  input wire logic [WIDTH-1:0] in_data, // word pushed
  output logic out_valid, // a word is available
  input wire logic out_ready, // pop request
  output logic [WIDTH-1:0] out_data // oldest word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic push;
  logic pop;

  always_comb
  begin
    in_ready = (wr_ptr - rd_ptr) != (AW + 1)'(DEPTH);
    out_valid = wr_ptr != rd_ptr;
    out_data = mem[rd_ptr[AW-1:0]];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + (AW + 1)'(1) : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + (AW + 1)'(1) : rd_ptr;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage needs no reset; only words below the write pointer are read.
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule : i2cmr_fifo
`default_nettype wire

// file: i2cmr_assertions.sv
// Purpose: Concurrent checks on the byte receiver's port behaviour.
// Assumes: One clock domain; nrst asynchronous, active low.
// Notes: Bound to every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
module i2cmr_assertions (
  input wire logic clk, // system clock
  input wire logic nrst, // reset, active low
  input wire logic buf_wr, // buffer write pulse
  input wire logic buf_rd, // buffer read pulse
  input wire logic start_req, // start pulse
  input wire logic receive_req, // receive pulse
  input wire logic ack_req, // ack pulse
  input wire logic ack_response_bit, // ack choice
  input wire logic sda_oe_n, // SDA enable
  input wire logic scl_oe_n, // SCL enable
  input wire logic [7:0] serial_data_buffer, // buffer
  input wire logic buffer_full_flag, // buffer full
  input wire logic port_interrupt_flag, // event flag
  input wire logic write_collision_flag, // collision flag
  input wire logic receive_overflow_flag, // overflow flag
  input wire logic start_condition_enable, // start busy
  input wire logic receive_enable_bit, // receive busy
  input wire logic ack_sequence_enable, // ack busy
  input wire logic port_idle // sequencer idle
);
  // ---------------------------------------------------------------
  // Clock counting
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [3:0] rises, next_rises;
  logic [1:0] mode, next_mode;
  logic scl_q, pif_q;
  // SCL releases are counted per transfer so the interrupt can be tied to the clock count.
  always_comb
  begin
    next_rises = rises + {3'h0, scl_oe_n & ~scl_q};
    next_mode = (port_interrupt_flag && !pif_q) ? 2'h0 : mode;
    if (port_idle && !start_req && (buf_wr || receive_req))
    begin
      next_rises = 4'h0;
      next_mode = buf_wr ? 2'h1 : 2'h2;
    end
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rises <= 4'h0;
      mode <= 2'h0;
      scl_q <= 1'b1;
      pif_q <= 1'b0;
    end
    else
    begin
      rises <= next_rises;
      mode <= next_mode;
      scl_q <= scl_oe_n;
      pif_q <= port_interrupt_flag;
    end
  end
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_byte_done;
    receive_enable_bit ##1 !receive_enable_bit;
  endsequence
  a_write_collision_flag_set: assert property (buf_wr && receive_enable_bit |=> write_collision_flag)
    else $error("collision flag missing");
  a_write_collision_flag_keep: assert property (buf_wr && receive_enable_bit && buffer_full_flag && !buf_rd
    |=> $stable(serial_data_buffer)) else $error("buffer changed by refused write");
  a_start_taken: assert property (start_req && port_idle |=> start_condition_enable)
    else $error("start not taken");
  a_start_done: assert property (start_condition_enable ##1 !start_condition_enable
    |-> ##[0:1] port_interrupt_flag) else $error("no flag after start");
  a_addr_ninth: assert property (port_interrupt_flag && !pif_q && mode == 2'h1
    |-> rises == 4'h9) else $error("address flag not after ninth clock");
  a_recv_eighth: assert property (port_interrupt_flag && !pif_q && mode == 2'h2
    |-> rises == 4'h8) else $error("receive flag not after eighth clock");
  a_byte_flags: assert property (s_byte_done
    |-> port_interrupt_flag && port_idle && !scl_oe_n ##1 buffer_full_flag)
    else $error("byte end flags wrong");
  a_ovf_set: assert property (receive_enable_bit && buffer_full_flag && !buf_rd
    ##1 !receive_enable_bit |-> receive_overflow_flag) else $error("overflow missing");
  a_recv_ignore: assert property (receive_req && !port_idle && !receive_enable_bit
    |=> !receive_enable_bit) else $error("busy receive request taken");
  a_rd_clears: assert property (buf_rd && buffer_full_flag |=> !buffer_full_flag)
    else $error("read left buffer full");
  a_ack_drive: assert property (ack_req && port_idle && !ack_response_bit && !start_req
    && !buf_wr && !receive_req |-> ##[1:4] !sda_oe_n) else $error("ack not driven");
  a_ack_done: assert property (ack_sequence_enable ##1 !ack_sequence_enable
    |-> ##[0:1] port_interrupt_flag) else $error("no flag after ack");
endmodule : i2cmr_assertions
bind i2cmr_top i2cmr_assertions i2cmr_assertions_i (.*);
`default_nettype wire

// file: i2cmr_slave_model.sv
// Purpose: Behavioural I2C slave that answers a read with counting bytes.
// Assumes: Sampled on the system clock, far faster than SCL.
// Notes: Each byte the master acknowledges is followed by the next value.
`timescale 1ns/1ps
`default_nettype none
module i2cmr_slave_model #(
  parameter logic [7:0] FIRST_BYTE = 8'h96
) (
  input wire logic clk, // sampling clock
  input wire logic sda, // SDA wire level
  input wire logic scl, // SCL wire level
  input wire logic ack_en, // acknowledge the address
  input wire logic [3:0] stretch, // cycles SCL is held low after each fall
  output logic sda_low, // pull SDA low
  output logic scl_low, // pull SCL low
  output logic [7:0] addr_seen // address byte shifted in
);
  // ---------------------------------------------------------------
  // Model
  // ---------------------------------------------------------------
  logic ps = 1'b1, pd = 1'b1, go = 1'b0;
  logic [7:0] tx = 8'h00, nx;
  logic [3:0] st = 4'h0;
  int cnt = 99, n;
  initial sda_low = 1'b0;
  initial addr_seen = 8'h00;
  assign scl_low = (st != 4'h0);
  always @(posedge clk)
  begin
    ps <= scl;
    pd <= sda;
    n = cnt + 1;
    nx = tx + 8'h01;
    if (st != 4'h0) st <= st - 4'h1;
    if (scl && ps && pd && !sda)
    begin
      cnt <= -1;
      tx <= FIRST_BYTE;
    end
    else if (scl && ps && !pd && sda)
      cnt <= 99;
    else if (scl && !ps)
    begin
      if (cnt >= 0 && cnt <= 7) addr_seen[7 - cnt] <= sda;
      if (cnt == 17) go <= !sda;
    end
    else if (!scl && ps)
    begin
      cnt <= n;
      st <= stretch;
      sda_low <= 1'b0;
      if (n == 8) sda_low <= ack_en;
      if (n == 8) go <= ack_en;
      if (go && n >= 9 && n <= 16) sda_low <= !tx[16 - n];
      if (go && n == 18)
      begin
        cnt <= 9;
        tx <= nx;
        sda_low <= !nx[7];
      end
    end
  end
endmodule : i2cmr_slave_model
`default_nettype wire

// file: tb_i2c_master_byte_receiver.sv
// Purpose: Self-checking bench for the I2C master byte receiver.
// Assumes: Short SCL half period of 4 clocks; open-drain lines pulled up.
// Notes: Requests are one-cycle pulses driven on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_master_byte_receiver;
  localparam logic [8:0] P_START = 9'h001, P_WR = 9'h002, P_RD = 9'h004, P_RX = 9'h008;
  localparam logic [8:0] P_ACK = 9'h010, P_STOP = 9'h020, P_ICLR = 9'h040;
  localparam logic [8:0] P_WCLR = 9'h080, P_OCLR = 9'h100;
  logic clk = 1'b0, nrst = 1'b0, ack_response_bit = 1'b0, ack_en = 1'b1, ack_seen;
  logic [8:0] req = 9'h000;
  logic [7:0] buf_wdata = 8'h00, serial_data_buffer, addr_seen;
  logic [3:0] stretch = 4'h0;
  logic sda_out, scl_out, sda_oe_n, scl_oe_n, s_sda_low, s_scl_low, port_idle;
  logic buffer_full_flag, port_interrupt_flag, write_collision_flag, receive_overflow_flag;
  logic ack_status_bit, start_condition_enable, receive_enable_bit, ack_sequence_enable;
  wire buf_wr, buf_rd, start_req, receive_req, ack_req, stop_req, int_clear, write_collision_flag_clear, ovf_clear;
  wire sda_in = sda_oe_n & ~s_sda_low;
  wire scl_in = scl_oe_n & ~s_scl_low;
  int bad_count = 0, num_checks = 0, falls = 0;
  assign {ovf_clear, write_collision_flag_clear, int_clear, stop_req, ack_req, receive_req, buf_rd, buf_wr,
    start_req} = req;
  always #12.5 clk = ~clk;
  always @(negedge scl_in) falls++;
  always @(posedge scl_in) if (ack_sequence_enable) ack_seen = sda_in;
  i2cmr_top #(.HALF_CYCLES(4)) i2cmr_top_i (.*);
  i2cmr_slave_model i2cmr_slave_model_i (.clk(clk), .sda(sda_in), .scl(scl_in),
    .ack_en(ack_en), .stretch(stretch), .sda_low(s_sda_low), .scl_low(s_scl_low),
    .addr_seen(addr_seen));
  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic pulse(input logic [8:0] v);
    @(negedge clk) req = v;
    @(negedge clk) req = 9'h000;
  endtask : pulse
  // A hung sequence ends the run here rather than stalling the bench.
  task automatic wait_int;
    for (int i = 0; i < 4000 && port_interrupt_flag !== 1'b1; i++) @(negedge clk);
    chk("port_interrupt_flag", 8'h01, {7'h0, port_interrupt_flag});
    if (port_interrupt_flag !== 1'b1) complete_run;
    pulse(P_ICLR);
  endtask : wait_int
  task automatic open_read(input logic [7:0] a);
    pulse(P_START);
    chk("start_condition_enable", 8'h01, {7'h0, start_condition_enable});
    wait_int;
    buf_wdata = a;
    falls = 0;
    pulse(P_WR);
    wait_int;
    chk("address clocks", 8'h09, falls[7:0]);
    chk("address on SDA", a, addr_seen);
  endtask : open_read
  task automatic rx_byte(input logic collide);
    falls = 0;
    pulse(P_RX);
    pulse(P_RX);
    buf_wdata = 8'h3c;
    if (collide) pulse(P_WR);
    if (collide) chk("write_collision_flag", 8'h01, {7'h0, write_collision_flag});
    wait_int;
    chk("byte clocks", 8'h08, falls[7:0]);
    chk("receive_enable_bit", 8'h00, {7'h0, receive_enable_bit});
    chk("SCL held low", 8'h00, {7'h0, scl_in});
    chk("buffer_full_flag", 8'h01, {7'h0, buffer_full_flag});
  endtask : rx_byte
  task automatic ack(input logic b);
    ack_response_bit = b;
    ack_seen = 1'bx;
    pulse(P_ACK);
    wait_int;
    chk("acknowledge on SDA", {7'h0, b}, {7'h0, ack_seen});
  endtask : ack
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial
  begin
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    chk("reset flags", 8'h00, {buffer_full_flag, port_interrupt_flag, write_collision_flag,
      receive_overflow_flag, ack_status_bit, start_condition_enable, receive_enable_bit,
      ack_sequence_enable});
    chk("reset lines", 8'h07, {3'h0, sda_out, scl_out, port_idle, sda_oe_n, scl_oe_n});
    open_read(8'ha5);
    chk("ack_status_bit", 8'h00, {7'h0, ack_status_bit});
    rx_byte(1'b0);
    chk("first byte", 8'h96, serial_data_buffer);
    pulse(P_RD);
    chk("buffer_full_flag", 8'h00, {7'h0, buffer_full_flag});
    ack(1'b0);
    rx_byte(1'b0);
    ack(1'b0);
    rx_byte(1'b1);
    chk("receive_overflow_flag", 8'h01, {7'h0, receive_overflow_flag});
    chk("unread byte kept", 8'h97, serial_data_buffer);
    pulse(P_RD | P_WCLR | P_OCLR);
    @(negedge clk);
    chk("queued byte", 8'h98, serial_data_buffer);
    pulse(P_RD);
    ack(1'b1);
    pulse(P_STOP);
    wait_int;
    chk("lines released", 8'h07, {5'h0, port_idle, sda_in, scl_in});
    // A slow slave that refuses its address, stretching every low phase.
    ack_en = 1'b0;
    stretch = 4'h6;
    open_read(8'h5b);
    chk("ack_status_bit", 8'h01, {7'h0, ack_status_bit});
    pulse(P_STOP);
    wait_int;
    complete_run;
  end
endmodule : tb_i2c_master_byte_receiver
`default_nettype wire
